// ===== logic/wake_pkg.sv
// Shared types and constants for the wake-event service block
package wake_pkg;

    // ==========================================================
    // Power state codes and timing
    // ==========================================================
    localparam logic [1:0] PSTATE_D0 = 2'h0;
    localparam logic [1:0] PSTATE_D3 = 2'h3;
    localparam int CLK_HZ = 50_000_000;
    localparam int SVC_LIMIT_MS = 100;
    localparam int SVC_MIN_MS = 95;
    localparam int SVC_MAX_MS = 150;
    localparam int SVC_CYCLES = SVC_LIMIT_MS * (CLK_HZ / 1000);
    localparam logic [23:0] TIMER_RESET = 24'h00_0000;

    // ==========================================================
    // Event message layout
    // ==========================================================
    localparam logic [7:0] MSG_FMT_TYPE = 8'h30;
    localparam logic [7:0] MSG_CODE = 8'h18;
    localparam int MSG_B0_POS = 0;
    localparam int MSG_B7_POS = 56;

    // ==========================================================
    // Wake source select codes
    // ==========================================================
    localparam logic SRC_PIN = 1'b0;
    localparam logic SRC_SERIAL = 1'b1;

    // Power state of the function as seen by the sequencer
    typedef enum {
        ST_D0,
        ST_D3HOT,
        ST_D3COLD
    } pstate_t;

    // Sticky flags kept across fundamental reset
    typedef struct packed {
        logic pme_status;
        logic pme_enable;
    } sticky_t;

    // Supply sensing inputs
    typedef struct packed {
        logic main_io;
        logic main_core;
        logic aux_io;
        logic aux_core;
    } supply_t;

    // Builds the four-doubleword event message
    function automatic logic [127:0] build_msg();
        logic [127:0] m;
        m = '0;
        m[MSG_B0_POS +: 8] = MSG_FMT_TYPE;
        m[MSG_B7_POS +: 8] = MSG_CODE;
        return m;
    endfunction : build_msg

endpackage : wake_pkg

// ===== logic/service_timer.sv
// Retransmission service timer
`timescale 1ns/1ps
module service_timer
    import wake_pkg::*;
#(
    parameter int LIMIT = SVC_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic restart,
    input wire logic stop,
    output logic expired
);

    typedef struct packed {
        logic [23:0] count;
        logic running;
    } tmr_state_t;

    tmr_state_t st_r;
    tmr_state_t st_nxt;

    // ==========================================================
    // Counter next state
    // ==========================================================
    always_comb
    begin
        st_nxt = st_r;
        if (stop)
        begin
            st_nxt.running = 1'b0;
            st_nxt.count = TIMER_RESET;
        end
        else if (restart)
        begin
            st_nxt.running = 1'b1;
            st_nxt.count = TIMER_RESET;
        end
        else if (st_r.running && !expired)
        begin
            st_nxt.count = st_r.count + 24'h00_0001;
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    // Expiry at the limit
    assign expired = st_r.running && (st_r.count == 24'(LIMIT - 1));

endmodule : service_timer

// ===== logic/pcie_wake_event_service.sv
// Wake-event detection, sideband wake and event message service
// Functional notes
// RULE_01 - Wake sequence and messages only while enable flag is one
// RULE_02 - Message: byte0 30h, doubleword1 byte3 18h, all other bytes zero
// RULE_03 - Wake event in D3hot or D3cold produces an event message
// RULE_04 - D3hot holds link in L1; wake moves to L0 before sending
// RULE_05 - D3hot wake source is pin or serial interrupt, chosen by select
// RULE_06 - D3cold gates serial clock low, resets ports, gates memories
// RULE_07 - Software reinitialises serial ports after D3cold return
// RULE_08 - D3cold wake event asserts active-low sideband wake output
// RULE_09 - After D3cold wake, send only after reset done and link L0
// RULE_10 - Each send sets status flag and restarts service timer
// RULE_11 - Software clears status flag after handling the message
// RULE_12 - Flag still set at timer limit: resend and restart, repeatedly
// RULE_13 - Wake request input pin accepted as a wake event
// RULE_14 - In D3cold wake request pin is forwarded to sideband wake
// RULE_15 - Main supply sensing tells D3hot from D3cold
// RULE_16 - Aux supply sensing drives the aux-power-detected flag
// RULE_17 - Driver puts serial ports to sleep before D3hot
// RULE_18 - Clearing status flag stops timer and cancels resend
// RULE_19 - Status and enable flags survive fundamental reset on aux power
// RULE_20 - Writing D0 code into power state field leaves D3hot
`timescale 1ns/1ps
module pcie_wake_event_service
    import wake_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic fundamental_reset_n,
    input wire supply_t supply,
    input wire logic wake_request_in,
    input wire logic serial_irq,
    input wire logic wake_source_select_reg,
    input wire logic [1:0] pstate_wr_data,
    input wire logic pstate_wr,
    input wire logic pme_enable_wr_data,
    input wire logic pme_enable_wr,
    input wire logic pme_status_clr,
    input wire logic link_in_l0,
    input wire logic msg_ready,
    output logic [127:0] msg_data,
    output logic msg_valid,
    output logic link_l1_req,
    output logic link_l0_req,
    output logic sideband_wake_out_n,
    output logic serial_clk_gate,
    output logic serial_reset,
    output logic mem_clk_gate,
    output logic aux_power_detected,
    output logic pme_status,
    output logic pme_enable,
    output logic [1:0] power_state
);

    // ==========================================================
    // Reset synchroniser
    // ==========================================================
    logic [1:0] rst_sync_r;
    logic rst_n;

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            rst_sync_r <= 2'b00;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end

    assign rst_n = rst_sync_r[1];

    // ==========================================================
    // State record
    // ==========================================================
    typedef struct packed {
        pstate_t pstate;
        sticky_t sticky;
        logic [1:0] pcode;
        logic wake_pending;
        logic cold_woken;
        logic sb_wake;
        logic wake_prev;
        logic send_req;
        logic [127:0] msg;
        logic valid;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic main_present;
    logic aux_present;
    logic wake_event;
    logic wake_level;
    logic timer_restart;
    logic timer_expired;
    logic sent;
    logic in_reset;

    // Supply detection
    assign main_present = supply.main_io && supply.main_core; // RULE_15
    assign aux_present = supply.aux_io && supply.aux_core;
    assign in_reset = !fundamental_reset_n;

    // Wake source per state
    always_comb
    begin
        wake_level = 1'b0;
        unique case (st_r.pstate)
            ST_D3HOT:
                wake_level = (wake_source_select_reg == SRC_SERIAL) ? serial_irq // RULE_05
                                                                    : wake_request_in; // RULE_13
            ST_D3COLD:
                wake_level = wake_request_in; // RULE_14
            ST_D0:
                wake_level = 1'b0;
        endcase
    end

    // Rising edge only, so a held source gives one event
    assign wake_event = wake_level && st_r.sticky.pme_enable && !st_r.wake_prev; // RULE_03

    assign sent = st_r.valid && msg_ready;

    // ==========================================================
    // Sequencer next state
    // ==========================================================
    always_comb
    begin
        st_nxt = st_r;
        timer_restart = 1'b0;
        if (sent)
        begin
            st_nxt.valid = 1'b0;
            st_nxt.sticky.pme_status = 1'b1; // RULE_10
            timer_restart = 1'b1; // RULE_10
        end
        if (pme_enable_wr)
            st_nxt.sticky.pme_enable = pme_enable_wr_data;
        // Set wins over a clear in the same cycle
        if (pme_status_clr && !sent)
            st_nxt.sticky.pme_status = 1'b0; // RULE_18
        if (pme_status_clr && !sent && !st_r.valid)
            st_nxt.send_req = 1'b0; // RULE_18
        if (pstate_wr)
            st_nxt.pcode = pstate_wr_data;
        // Power state tracking
        unique case (st_r.pstate)
            ST_D0:
            begin
                if (pstate_wr && pstate_wr_data == PSTATE_D3)
                    st_nxt.pstate = main_present ? ST_D3HOT : ST_D3COLD;
            end
            ST_D3HOT:
            begin
                if (!main_present)
                    st_nxt.pstate = ST_D3COLD; // RULE_15
                else if (pstate_wr && pstate_wr_data == PSTATE_D0)
                    st_nxt.pstate = ST_D0; // RULE_20
            end
            ST_D3COLD:
            begin
                if (st_r.cold_woken && main_present && !in_reset)
                begin
                    st_nxt.pstate = ST_D0;
                    st_nxt.pcode = PSTATE_D0;
                end
            end
        endcase
        // Wake capture
        if (wake_event && st_r.sticky.pme_enable) // RULE_01
        begin
            st_nxt.wake_pending = 1'b1; // RULE_03
            if (st_r.pstate == ST_D3COLD)
                st_nxt.cold_woken = 1'b1;
        end
        // Edge detector follows the gated source level
        st_nxt.wake_prev = wake_level && st_r.sticky.pme_enable;
        // Sideband is set by the pin in D3cold and held until main power returns
        if (st_r.pstate == ST_D3COLD && wake_level && st_r.sticky.pme_enable && !main_present)
            st_nxt.sb_wake = 1'b1; // RULE_08
        // Release sideband once main power returns
        if (st_r.sb_wake && main_present)
            st_nxt.sb_wake = 1'b0;
        // Send once link is L0 and reset finished
        if (st_r.wake_pending && link_in_l0 && !in_reset && !st_r.valid) // RULE_04 RULE_09
        begin
            st_nxt.wake_pending = 1'b0;
            st_nxt.cold_woken = st_r.cold_woken && !main_present;
            st_nxt.send_req = st_r.sticky.pme_enable; // RULE_01
        end
        // One resend per expiry: the timer restarts only on acceptance
        if (timer_expired && st_r.sticky.pme_status && !pme_status_clr
            && st_r.sticky.pme_enable && !st_r.valid && !st_r.send_req)
            st_nxt.send_req = 1'b1; // RULE_12
        if (st_r.send_req && !st_r.valid && link_in_l0 && st_r.sticky.pme_enable) // RULE_01
        begin
            st_nxt.send_req = 1'b0;
            st_nxt.valid = 1'b1;
            st_nxt.msg = build_msg(); // RULE_02
        end
        if (!st_r.sticky.pme_enable)
        begin
            st_nxt.wake_pending = 1'b0;
            st_nxt.send_req = 1'b0;
        end
    end

    // ==========================================================
    // Registers: sticky flags only cleared by resetn or loss of both aux and main power
    // ==========================================================
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            st_r <= '0;
        else if (!aux_present && !main_present)
            st_r <= '0;
        else if (in_reset)
        begin
            st_r <= '0;
            st_r.sticky <= st_nxt.sticky; // RULE_19
            st_r.pstate <= st_nxt.pstate;
            st_r.pcode <= st_nxt.pcode;
            st_r.cold_woken <= st_nxt.cold_woken; // RULE_09
            st_r.wake_pending <= st_nxt.wake_pending; // RULE_09
            st_r.wake_prev <= st_nxt.wake_prev;
            st_r.sb_wake <= st_nxt.sb_wake;
        end
        else
            st_r <= st_nxt;
    end

    // Service timer
    service_timer u_timer (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .restart(timer_restart),
        .stop((pme_status_clr && !sent) || !st_r.sticky.pme_enable), // RULE_18
        .expired(timer_expired)
    );

    // ==========================================================
    // Outputs
    // ==========================================================
    assign msg_data = st_r.msg;
    assign msg_valid = st_r.valid;
    assign link_l1_req = (st_r.pstate == ST_D3HOT) && !link_l0_req; // RULE_04
    assign link_l0_req = st_r.wake_pending || st_r.send_req || st_r.valid; // RULE_04
    assign sideband_wake_out_n = !st_r.sb_wake; // RULE_08
    assign serial_clk_gate = (st_r.pstate != ST_D3COLD); // RULE_06
    assign serial_reset = (st_r.pstate == ST_D3COLD); // RULE_06
    assign mem_clk_gate = (st_r.pstate != ST_D3COLD); // RULE_06
    assign aux_power_detected = aux_present; // RULE_16
    assign pme_status = st_r.sticky.pme_status;
    assign pme_enable = st_r.sticky.pme_enable;
    assign power_state = st_r.pcode;

    // ==========================================================
    // Checks
    // ==========================================================
    cold_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_06
        (st_r.pstate == ST_D3COLD) |-> (!serial_clk_gate && serial_reset && !mem_clk_gate))
        else $error("serial clock not gated in D3cold");

    msg_format_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_02
        msg_valid |-> (msg_data == {64'h0, MSG_CODE, 48'h0, MSG_FMT_TYPE}))
        else $error("event message malformed");

    send_sets_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_10
        (sent && !in_reset && (aux_present || main_present)) |=> pme_status)
        else $error("status not set after send");

    enable_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_01
        (!pme_enable && !msg_valid) |=> !msg_valid)
        else $error("message raised while disabled");

    clear_stop_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_18
        pme_status_clr |=> !timer_expired)
        else $error("timer still running after clear");

    l0_before_send_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_04
        $rose(msg_valid) |-> $past(link_in_l0))
        else $error("message raised outside L0");

    aux_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_16
        aux_power_detected == (supply.aux_io && supply.aux_core))
        else $error("aux flag mismatch");

    sb_wake_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_14
        (st_r.pstate == ST_D3COLD && wake_request_in && pme_enable && !in_reset
         && aux_present && !main_present) |=> !sideband_wake_out_n)
        else $error("sideband wake not asserted");

    resend_req_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_12
        (timer_expired && pme_status && pme_enable && !pme_status_clr && !msg_valid
         && !st_r.send_req && !in_reset && (aux_present || main_present)) |=> link_l0_req)
        else $error("no resend at timer limit");

    wake_capture_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_03
        (wake_event && (aux_present || main_present)) |=> link_l0_req)
        else $error("wake event not captured");

    cold_entry_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_15
        (st_r.pstate == ST_D0 && pstate_wr && pstate_wr_data == PSTATE_D3 && !main_present
         && aux_present) |=> serial_reset)
        else $error("D3 entry without main power not cold");

    hot_exit_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_20
        (st_r.pstate == ST_D3HOT && main_present && pstate_wr && pstate_wr_data == PSTATE_D0)
        |=> ((power_state == PSTATE_D0) && !link_l1_req))
        else $error("D0 write did not leave D3hot");

    send_after_reset_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE_09
        $rose(msg_valid) |-> !$past(in_reset))
        else $error("message raised during fundamental reset");

endmodule : pcie_wake_event_service

// ===== tb/rc_link_model.sv
// Root complex side model: link training and message intake
`timescale 1ns/1ps
module rc_link_model
(
    input wire logic sys_clk,
    input wire logic link_ok,
    input wire logic link_l1_req,
    input wire logic link_l0_req,
    input wire logic msg_valid,
    input wire logic [127:0] msg_data,
    output logic link_in_l0,
    output logic msg_ready,
    output int msg_count,
    output int link_err,
    output logic [127:0] last_msg
);
    int dly;

    // ==========================================================
    // Start idle
    // ==========================================================
    initial
    begin
        link_in_l0 = 1'b0;
        msg_ready = 1'b0;
        msg_count = 0;
        link_err = 0;
        last_msg = '0;
        dly = 0;
    end

    // Link trains a few cycles after L1 is released
    always @(posedge sys_clk)
    begin
        if (!link_ok || (link_l1_req && !link_l0_req))
        begin
            link_in_l0 <= 1'b0;
            dly <= $urandom_range(4, 1);
        end
        else if (dly > 0)
            dly <= dly - 1;
        else
            link_in_l0 <= 1'b1;
    end

    // Accept with random stalls; a send outside L0 is logged
    always @(posedge sys_clk)
    begin
        if (msg_valid && msg_ready)
        begin
            msg_count <= msg_count + 1;
            last_msg <= msg_data;
            if (!link_in_l0)
                link_err <= link_err + 1;
        end
        msg_ready <= ($urandom_range(3, 0) != 0);
    end
endmodule : rc_link_model

// ===== tb/pcie_wake_event_service_bench.sv
// Self-checking bench for the wake-event service block
`timescale 1ns/1ps
module pcie_wake_event_service_bench
    import wake_pkg::*;
();
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic fundamental_reset_n = 1'b1;
    supply_t supply = 4'hf;
    logic wake_request_in = 1'b0;
    logic serial_irq = 1'b0;
    logic wake_source_select_reg = 1'b0;
    logic [1:0] pstate_wr_data = 2'h0;
    logic pstate_wr = 1'b0;
    logic pme_enable_wr_data = 1'b0;
    logic pme_enable_wr = 1'b0;
    logic pme_status_clr = 1'b0;
    logic link_in_l0, msg_ready, msg_valid, link_l1_req, link_l0_req;
    logic sideband_wake_out_n, serial_clk_gate, serial_reset, mem_clk_gate;
    logic aux_power_detected, pme_status, pme_enable, link_ok, s;
    logic [1:0] power_state;
    logic [127:0] msg_data, last_msg;
    int msg_count, link_err, n;
    int mismatches = 0;
    int cmp_count = 0;

    assign link_ok = supply.main_io & supply.main_core & fundamental_reset_n;
    initial forever #10 sys_clk = ~sys_clk;

    pcie_wake_event_service dut (.sys_clk, .resetn, .fundamental_reset_n, .supply,
        .wake_request_in, .serial_irq, .wake_source_select_reg, .pstate_wr_data,
        .pstate_wr, .pme_enable_wr_data, .pme_enable_wr, .pme_status_clr, .link_in_l0,
        .msg_ready, .msg_data, .msg_valid, .link_l1_req, .link_l0_req,
        .sideband_wake_out_n, .serial_clk_gate, .serial_reset, .mem_clk_gate,
        .aux_power_detected, .pme_status, .pme_enable, .power_state);

    rc_link_model rc (.sys_clk, .link_ok, .link_l1_req, .link_l0_req, .msg_valid,
        .msg_data, .link_in_l0, .msg_ready, .msg_count, .link_err, .last_msg);

    // ==========================================================
    // Helpers
    // ==========================================================
    function automatic logic [127:0] exp_msg();
        logic [127:0] m;
        m = '0;
        m[7:0] = 8'h30;
        m[63:56] = 8'h18;
        return m;
    endfunction : exp_msg

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask : cyc

    task automatic wr_state(input logic [1:0] v);
        @(posedge sys_clk);
        pstate_wr_data <= v;
        pstate_wr <= 1'b1;
        @(posedge sys_clk);
        pstate_wr <= 1'b0;
        cyc(2);
    endtask : wr_state

    task automatic wr_en(input logic v);
        @(posedge sys_clk);
        pme_enable_wr_data <= v;
        pme_enable_wr <= 1'b1;
        @(posedge sys_clk);
        pme_enable_wr <= 1'b0;
    endtask : wr_en

    task automatic clr_status();
        @(posedge sys_clk);
        pme_status_clr <= 1'b1;
        @(posedge sys_clk);
        pme_status_clr <= 1'b0;
        cyc(1);
    endtask : clr_status

    task automatic src(input logic sel, input logic v);
        @(posedge sys_clk);
        if (sel)
            serial_irq <= v;
        else
            wake_request_in <= v;
    endtask : src

    task automatic wait_msg(input int want);
        int i;
        i = 0;
        while (msg_count != want && i < 200)
        begin
            cyc(1);
            i++;
        end
    endtask : wait_msg

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    // Watchdog against a hung sequence
    initial
    begin
        #1_000_000;
        mismatches++;
        test_done();
    end

    // ==========================================================
    // Tests
    // ==========================================================
    initial
    begin
        void'($urandom(32'h719d_7e27));
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        cyc(3);
        check(msg_valid, 1'b0);
        check(sideband_wake_out_n, 1'b1);
        check(serial_clk_gate, 1'b1);
        check(serial_reset, 1'b0);
        @(posedge sys_clk);
        supply <= 4'hc;
        cyc(1);
        check(aux_power_detected, 1'b0);
        @(posedge sys_clk);
        supply <= 4'hf;
        cyc(1);
        check(aux_power_detected, 1'b1);
        $display("test reset and aux done");
        // Wake with enable clear is ignored
        wr_en(1'b0);
        wr_state(2'h3);
        check(power_state, 2'h3);
        src(1'b0, 1'b1);
        cyc(40);
        check(msg_count, 0);
        check(pme_status, 1'b0);
        check(link_l0_req, 1'b0);
        src(1'b0, 1'b0);
        wr_state(2'h0);
        $display("test disabled done");
        // D3hot wakes from randomly chosen source
        wr_en(1'b1);
        repeat (4)
        begin
            s = $urandom_range(1, 0);
            n = msg_count;
            @(posedge sys_clk);
            wake_source_select_reg <= s;
            // Unselected source is pulsed first and must not wake from D3hot
            wr_state(2'h3);
            check(link_l1_req, 1'b1);
            check(serial_clk_gate, 1'b1);
            src(~s, 1'b1);
            cyc($urandom_range(20, 5));
            src(~s, 1'b0);
            check(msg_count, n);
            src(s, 1'b1);
            wait_msg(n + 1);
            check(msg_count, n + 1);
            check(last_msg, exp_msg());
            check(link_err, 0);
            src(s, 1'b0);
            cyc(1);
            check(pme_status, 1'b1);
            cyc(300);
            check(msg_count, n + 1);
            clr_status();
            check(pme_status, 1'b0);
            wr_state(2'h0);
            check(power_state, 2'h0);
        end
        $display("test d3hot done");
        // D3cold: gating, sideband wake, send after reset and L0
        n = msg_count;
        @(posedge sys_clk);
        supply <= 4'h3;
        wr_state(2'h3);
        check(serial_clk_gate, 1'b0);
        check(serial_reset, 1'b1);
        check(mem_clk_gate, 1'b0);
        check(sideband_wake_out_n, 1'b1);
        @(posedge sys_clk);
        fundamental_reset_n <= 1'b0;
        src(1'b0, 1'b1);
        cyc(4);
        check(sideband_wake_out_n, 1'b0);
        check(pme_enable, 1'b1);
        @(posedge sys_clk);
        supply <= 4'hf;
        cyc(10);
        check(msg_count, n);
        check(sideband_wake_out_n, 1'b1);
        @(posedge sys_clk);
        fundamental_reset_n <= 1'b1;
        wait_msg(n + 1);
        check(last_msg, exp_msg());
        check(link_err, 0);
        check(power_state, 2'h0);
        check(serial_reset, 1'b0);
        check(serial_clk_gate, 1'b1);
        src(1'b0, 1'b0);
        cyc(1);
        check(pme_status, 1'b1);
        check(sideband_wake_out_n, 1'b1);
        clr_status();
        $display("test d3cold done");
        test_done();
    end
endmodule : pcie_wake_event_service_bench
